// [src/sih_core.sv]
// stepper io handshake core: ready, fast home, jog, alarm and inhibit logic
`timescale 1ns/1ps
module sih_core import sih_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire sih_in_type pins_in,
    output sih_out_type pins_out,
    output logic single_pulse_mode,
    output logic irq
);
    typedef struct packed {
        sih_state_type state;
        logic boot;
        logic ready;
        logic home_done;
        logic alarm;
        logic blink;
        logic [7:0] blink_cnt;
        logic [7:0] cnt;
        logic [31:0] pos;
        logic [31:0] home_pos;
        logic step;
        logic dir_forward;
        logic cfg_pulse_mode;
        logic single_pulse_mode;
        logic [SIH_IRQ_W-1:0] irq_stat;
        logic [SIH_IRQ_W-1:0] irq_mask;
    } sih_core_type;

    sih_core_type c_r;
    sih_core_type c_nxt;
    logic wr_en;
    logic [7:0] reg_addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic both_jog;
    logic any_jog;
    logic inhibit;
    logic deenergize;
    logic at_home;
    logic step_tick;
    logic [SIH_IRQ_W-1:0] irq_evt;

    sih_ahb_slave u_slave (
        .clk(clk),
        .sys_rst(sys_rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .rd_en(),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    assign both_jog = pins_in.forward_jog_request && pins_in.reverse_jog_request;
    assign any_jog = pins_in.forward_jog_request || pins_in.reverse_jog_request;
    assign deenergize = pins_in.stop_and_deenergize_input || !pins_in.current_on_input;
    // anything that forbids motion start or ends motion
    assign inhibit = c_r.alarm || pins_in.stop_input || pins_in.shaft_release_input
        || deenergize;
    assign at_home = pins_in.home_sensor || (c_r.pos == c_r.home_pos);
    assign step_tick = (c_r.cnt == 8'h00);

    // register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (reg_addr == SIH_OFF_STATUS) begin
            rd_data = {24'h000000, c_r.single_pulse_mode, c_r.alarm, c_r.home_done,
                c_r.ready, 1'b0, c_r.state};
        end else if (reg_addr == SIH_OFF_IRQ_STAT) begin
            rd_data = {29'h0, c_r.irq_stat};
        end else if (reg_addr == SIH_OFF_IRQ_MASK) begin
            rd_data = {29'h0, c_r.irq_mask};
        end else if (reg_addr == SIH_OFF_HOME) begin
            rd_data = c_r.home_pos;
        end else if (reg_addr == SIH_OFF_POS) begin
            rd_data = c_r.pos;
        end else if (reg_addr == SIH_OFF_CFG) begin
            rd_data = {31'h0, c_r.cfg_pulse_mode};
        end
    end

    always_comb begin
        c_nxt = c_r;
        irq_evt = '0;
        c_nxt.step = 1'b0;
        c_nxt.boot = 1'b0;
        // pulse mode sampled only in the first cycle after reset release
        if (c_r.boot) begin
            c_nxt.single_pulse_mode = pins_in.pulse_mode_dip_switch
                || c_r.cfg_pulse_mode;
            c_nxt.ready = 1'b1;
        end
        c_nxt.blink_cnt = c_r.blink_cnt + 8'h01;
        if (c_r.blink_cnt == 8'hff) begin
            c_nxt.blink = !c_r.blink;
        end
        if (pins_in.alarm_cause && !c_r.alarm) begin
            c_nxt.alarm = 1'b1;
            irq_evt[SIH_IRQ_ALARM] = 1'b1;
        end
        c_nxt.cnt = step_tick ? SIH_STEP_CYCLES : c_r.cnt - 8'h01;
        case (c_r.state)
            SIH_IDLE: begin
                if (c_r.ready && !inhibit && pins_in.fast_home_request) begin
                    c_nxt.ready = 1'b0;
                    c_nxt.home_done = 1'b0;
                    c_nxt.state = SIH_HOMING;
                end else if (c_r.ready && both_jog) begin
                    c_nxt.state = SIH_LOCKOUT;
                    irq_evt[SIH_IRQ_JOG_CONFLICT] = 1'b1;
                end else if (c_r.ready && !inhibit && any_jog) begin
                    c_nxt.ready = 1'b0;
                    c_nxt.home_done = 1'b0;
                    c_nxt.dir_forward = pins_in.forward_jog_request;
                    c_nxt.state = SIH_JOG;
                end
            end
            SIH_HOMING: begin
                if (inhibit) begin
                    c_nxt.state = SIH_IDLE;
                    c_nxt.ready = 1'b1;
                end else if (at_home) begin
                    c_nxt.home_done = 1'b1;
                    c_nxt.ready = 1'b1;
                    c_nxt.pos = c_r.home_pos;
                    c_nxt.state = SIH_IDLE;
                    irq_evt[SIH_IRQ_HOME_DONE] = 1'b1;
                end else if (step_tick) begin
                    // travel toward the stored home target
                    c_nxt.dir_forward = $signed(c_r.home_pos - c_r.pos) > 0;
                    c_nxt.step = 1'b1;
                    c_nxt.pos = c_nxt.dir_forward ? c_r.pos + 32'h1 : c_r.pos - 32'h1;
                end
            end
            SIH_JOG: begin
                if (both_jog) begin
                    c_nxt.state = SIH_LOCKOUT;
                    irq_evt[SIH_IRQ_JOG_CONFLICT] = 1'b1;
                end else if (inhibit) begin
                    c_nxt.state = SIH_IDLE;
                    c_nxt.ready = 1'b1;
                end else if (!(c_r.dir_forward ? pins_in.forward_jog_request
                        : pins_in.reverse_jog_request)) begin
                    c_nxt.state = SIH_DECEL;
                    c_nxt.cnt = SIH_DECEL_CYCLES;
                end else if (step_tick) begin
                    c_nxt.step = 1'b1;
                    c_nxt.pos = c_r.dir_forward ? c_r.pos + 32'h1 : c_r.pos - 32'h1;
                end
            end
            SIH_DECEL: begin
                // one ramp count stands in for the deceleration profile
                if (step_tick || inhibit) begin
                    c_nxt.state = SIH_IDLE;
                    c_nxt.ready = 1'b1;
                end else begin
                    c_nxt.cnt = c_r.cnt - 8'h01;
                end
            end
            SIH_LOCKOUT: begin
                c_nxt.ready = 1'b1;
                if (!any_jog) begin
                    c_nxt.state = SIH_IDLE;
                end
            end
            default: c_nxt.state = SIH_IDLE;
        endcase
        if (wr_en) begin
            if (reg_addr == SIH_OFF_CTRL) begin
                // clear refused while the cause persists
                if (wr_data[SIH_CTRL_ALM_CLR] && !pins_in.alarm_cause) begin
                    c_nxt.alarm = 1'b0;
                end
                if (wr_data[SIH_CTRL_HOME_SET]) begin
                    c_nxt.home_pos = c_r.pos;
                end
                if (wr_data[SIH_CTRL_ALM_SET]) begin
                    c_nxt.alarm = 1'b1;
                    irq_evt[SIH_IRQ_ALARM] = 1'b1;
                end
            end else if (reg_addr == SIH_OFF_IRQ_MASK) begin
                c_nxt.irq_mask = wr_data[SIH_IRQ_W-1:0];
            end else if (reg_addr == SIH_OFF_HOME) begin
                c_nxt.home_pos = wr_data;
            end else if (reg_addr == SIH_OFF_CFG) begin
                // held until next reset, the stand-in for a power cycle
                c_nxt.cfg_pulse_mode = wr_data[SIH_CFG_PULSE_MODE];
            end
        end
        // set wins over write-one-to-clear
        c_nxt.irq_stat = c_r.irq_stat;
        if (wr_en && reg_addr == SIH_OFF_IRQ_STAT) begin
            c_nxt.irq_stat = c_r.irq_stat & ~wr_data[SIH_IRQ_W-1:0];
        end
        c_nxt.irq_stat = c_nxt.irq_stat | irq_evt;
        if (c_nxt.alarm) begin
            c_nxt.ready = 1'b0;
            c_nxt.state = SIH_IDLE;
        end else if (c_r.alarm) begin
            c_nxt.ready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c_r <= '0;
            c_r.state <= SIH_IDLE;
            c_r.boot <= 1'b1;
            c_r.home_pos <= SIH_HOME_RESET;
        end else begin
            c_r <= c_nxt;
        end
    end

    // cfg survives reset is not modelled; a reset counts as power cycle
    always_comb begin
        pins_out.ready = c_r.ready;
        pins_out.pulse_input_ready = c_r.ready && !c_r.boot;
        pins_out.home_done = c_r.home_done;
        pins_out.alarm_output_active_low = !c_r.alarm;
        pins_out.status_red_blink = c_r.alarm && c_r.blink;
        pins_out.winding_enable = !pins_in.shaft_release_input && !deenergize;
        pins_out.dynamic_brake = deenergize && !pins_in.shaft_release_input;
        pins_out.step = c_r.step;
        pins_out.dir_forward = c_r.dir_forward;
    end
    assign single_pulse_mode = c_r.single_pulse_mode;
    assign irq = |(c_r.irq_stat & c_r.irq_mask);

    a_alarm_out: assert property (@(posedge clk) disable iff (sys_rst)
        c_r.alarm |-> !pins_out.alarm_output_active_low)
        else $error("alarm output not off during alarm");
    a_clear_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(c_r.alarm) |-> !$past(pins_in.alarm_cause))
        else $error("alarm cleared while cause present");
    a_home_ready: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_IDLE && c_r.ready && !inhibit && pins_in.fast_home_request)
        |=> !c_r.ready && c_r.state == SIH_HOMING)
        else $error("home request did not drop ready");
    a_home_done: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(c_r.home_done) |-> c_r.ready && c_r.pos == c_r.home_pos)
        else $error("home done without ready at home");
    a_conflict_still: assert property (@(posedge clk) disable iff (sys_rst)
        c_r.state == SIH_LOCKOUT |-> !c_r.step)
        else $error("motion during jog conflict");
    a_stop_nostart: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_IDLE && pins_in.stop_input) |=> c_r.state != SIH_JOG
        && c_r.state != SIH_HOMING)
        else $error("motion started under stop");
    a_release_free: assert property (@(posedge clk) disable iff (sys_rst)
        pins_in.shaft_release_input |-> !pins_out.winding_enable && !pins_out.dynamic_brake)
        else $error("windings energized under shaft release");
    a_jog_decel: assert property (@(posedge clk) disable iff (sys_rst || c_r.alarm)
        c_r.state == SIH_DECEL |-> ##[1:20] c_r.ready)
        else $error("ready not back after jog stop");
    a_boot_ready: assert property (@(posedge clk)
        $fell(sys_rst) |=> ##1 pins_out.ready || c_r.alarm)
        else $error("ready not raised after reset");

    // a register write or a new alarm in the same cycle overrides the move logic
    a_pulse_ready: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.ready && !c_r.boot) |-> pins_out.pulse_input_ready)
        else $error("pulse ready missing while ready");
    a_jog_start: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_IDLE && c_r.ready && !inhibit && any_jog && !both_jog
        && !pins_in.fast_home_request && !pins_in.alarm_cause && !wr_en)
        |=> c_r.state == SIH_JOG && !c_r.ready)
        else $error("jog request did not start motion");
    a_jog_dir: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(c_r.state == SIH_JOG) |-> c_r.dir_forward == $past(pins_in.forward_jog_request))
        else $error("jog direction does not follow request");
    a_jog_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_JOG && !inhibit && !both_jog && !pins_in.alarm_cause && !wr_en
        && (c_r.dir_forward ? pins_in.forward_jog_request : pins_in.reverse_jog_request))
        |=> c_r.state == SIH_JOG)
        else $error("jog ended while request held");
    a_jog_release: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_JOG && !inhibit && !both_jog && !pins_in.alarm_cause && !wr_en
        && !(c_r.dir_forward ? pins_in.forward_jog_request : pins_in.reverse_jog_request))
        |=> c_r.state == SIH_DECEL && !c_r.ready && !c_r.step)
        else $error("jog release did not decelerate");
    a_conflict_enter: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_IDLE && c_r.ready && both_jog && !pins_in.fast_home_request
        && !pins_in.alarm_cause && !wr_en) |=> c_r.state == SIH_LOCKOUT)
        else $error("jog conflict not locked out");
    a_brake_coff: assert property (@(posedge clk) disable iff (sys_rst)
        (deenergize && !pins_in.shaft_release_input) |-> pins_out.dynamic_brake)
        else $error("no dynamic brake in non-excitation");
    a_home_target: assert property (@(posedge clk) disable iff (sys_rst)
        (c_r.state == SIH_HOMING && c_r.step) |-> (c_r.dir_forward
        ? $signed(c_r.home_pos - c_r.pos) >= 0 : $signed(c_r.home_pos - c_r.pos) <= 0))
        else $error("homing step away from stored home");
    a_irq_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        irq_evt != '0 |=> (c_r.irq_stat & $past(irq_evt)) == $past(irq_evt))
        else $error("interrupt event lost");
    a_alarm_ready: assert property (@(posedge clk) disable iff (sys_rst)
        c_r.alarm |-> !pins_out.ready)
        else $error("ready shown during alarm");
    a_alarm_set: assert property (@(posedge clk) disable iff (sys_rst)
        (pins_in.alarm_cause && !c_r.alarm) |=> c_r.alarm)
        else $error("alarm cause not latched");
    a_mode_latched: assert property (@(posedge clk) disable iff (sys_rst)
        !c_r.boot |=> $stable(c_r.single_pulse_mode))
        else $error("pulse mode changed without power cycle");
    a_release_still: assert property (@(posedge clk) disable iff (sys_rst)
        pins_in.shaft_release_input |=> !c_r.step)
        else $error("step issued under shaft release");
endmodule // sih_core

// [src/sih_pkg.sv]
// package: constants, register map and state types of the stepper io handshake block
package sih_pkg;
    localparam logic [7:0] SIH_OFF_CTRL = 8'h00;
    localparam logic [7:0] SIH_OFF_STATUS = 8'h04;
    localparam logic [7:0] SIH_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] SIH_OFF_IRQ_MASK = 8'h0c;
    localparam logic [7:0] SIH_OFF_HOME = 8'h10;
    localparam logic [7:0] SIH_OFF_POS = 8'h14;
    localparam logic [7:0] SIH_OFF_CFG = 8'h18;
    // ctrl bits (write): alarm reset pulse, home set pulse, alarm inject pulse
    localparam int SIH_CTRL_ALM_CLR = 0;
    localparam int SIH_CTRL_HOME_SET = 1;
    localparam int SIH_CTRL_ALM_SET = 2;
    // cfg bits: pulse mode parameter
    localparam int SIH_CFG_PULSE_MODE = 0;
    // irq bits
    localparam int SIH_IRQ_ALARM = 0;
    localparam int SIH_IRQ_HOME_DONE = 1;
    localparam int SIH_IRQ_JOG_CONFLICT = 2;
    localparam int SIH_IRQ_W = 3;
    // deceleration ramp and step period, in cycles
    localparam logic [7:0] SIH_DECEL_CYCLES = 8'h10;
    localparam logic [7:0] SIH_STEP_CYCLES = 8'h04;
    localparam logic [31:0] SIH_HOME_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        SIH_IDLE, SIH_HOMING, SIH_JOG, SIH_DECEL, SIH_LOCKOUT
    } sih_state_type;

    typedef struct packed {
        logic fast_home_request;
        logic forward_jog_request;
        logic reverse_jog_request;
        logic stop_input;
        logic stop_and_deenergize_input;
        logic current_on_input;
        logic shaft_release_input;
        logic home_sensor;
        logic alarm_cause;
        logic pulse_mode_dip_switch;
    } sih_in_type;

    typedef struct packed {
        logic ready;
        logic pulse_input_ready;
        logic home_done;
        logic alarm_output_active_low;
        logic status_red_blink;
        logic winding_enable;
        logic dynamic_brake;
        logic step;
        logic dir_forward;
    } sih_out_type;
endpackage

// [src/sih_ahb_slave.sv]
// ahb-lite single-word slave front end of the stepper io handshake block
`timescale 1ns/1ps
module sih_ahb_slave import sih_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] reg_addr,
    output logic [31:0] wr_data,
    input wire logic [31:0] rd_data
);
    typedef struct packed {
        logic wr_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
    } sih_slv_type;

    sih_slv_type s_r;
    sih_slv_type s_nxt;
    logic take;

    // a new transfer during a landing write waits one cycle: both would need reg_addr
    assign take = hsel && hready && htrans[1];
    assign hreadyout = !(s_r.wr_pend && hsel && htrans[1]);
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign wr_en = s_r.wr_pend;
    assign reg_addr = take ? haddr[7:0] : s_r.addr;
    assign wr_data = hwdata;
    assign rd_en = take && !hwrite;

    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_pend = take && hwrite;
        if (take) begin
            s_nxt.addr = haddr[7:0];
        end
        // read data captured at the address edge, presented in the data phase
        if (take && !hwrite) begin
            s_nxt.rdata = rd_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule // sih_ahb_slave

// [test/sih_host_model.sv]
// host controller model: fast home handshake and a home sensor
`timescale 1ns/1ps
module sih_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic ready,
    input wire logic step,
    input wire logic [7:0] sensor_after,
    output logic fast_home_request,
    output logic home_sensor
);
    logic [1:0] ph_r;
    logic [7:0] cnt_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            ph_r <= 2'h0;
            fast_home_request <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            if (go) begin
                cnt_r <= 8'h00;
            end else if (step && cnt_r != 8'hff) begin
                cnt_r <= cnt_r + 8'h01;
            end
            case (ph_r)
                2'h0: if (go) ph_r <= 2'h1;
                2'h1: if (ready) begin
                    fast_home_request <= 1'b1;
                    ph_r <= 2'h2;
                end
                // request held until the driver has visibly taken it
                2'h2: if (!ready) begin
                    fast_home_request <= 1'b0;
                    ph_r <= 2'h0;
                end
                default: ph_r <= 2'h0;
            endcase
        end
    end
    // zero means no sensor: the move then ends on the stored position
    assign home_sensor = (sensor_after != 8'h00) && (cnt_r >= sensor_after);
endmodule // sih_host_model

// [test/stepper_io_handshake_tb_top.sv]
// self-checking bench of the stepper io handshake core
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin n_mismatch++; $display("BAD %s exp=%h got=%h", n, e, g); end end
module stepper_io_handshake_tb_top import sih_pkg::*; ;
    typedef struct {string n; logic [31:0] e; logic [31:0] m;} sih_note_type;
    sih_note_type q[$];
    sih_note_type nt;
    event res_ev;
    logic clk, sys_rst, hsel, hwrite, go, hreadyout, hresp, single_pulse_mode, irq, fhr, hs;
    logic [31:0] haddr, hwdata, hrdata, got, rd, d;
    logic [31:0] seed = 32'h0001_32b2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] sens;
    // {current on, deenergize, shaft release, winding, brake}
    logic [4:0] wtab [5] = '{5'b00001, 5'b11001, 5'b00100, 5'b11100, 5'b10010};
    int n_mismatch = 0;
    int tests_run = 0;
    int steps = 0;
    int s0, n_tot, k2;
    sih_in_type pi, pins_in;
    sih_out_type pins_out;
    always_comb begin
        pins_in = pi;
        pins_in.fast_home_request = fhr;
        pins_in.home_sensor = hs;
    end
    sih_core DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_in(pins_in),
        .pins_out(pins_out), .single_pulse_mode(single_pulse_mode), .irq(irq));
    sih_host_model HOST (.clk(clk), .sys_rst(sys_rst), .go(go), .ready(pins_out.ready),
        .step(pins_out.step), .sensor_after(sens), .fast_home_request(fhr), .home_sensor(hs));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (pins_out.step === 1'b1) steps++;
    initial begin
        forever begin
            @(res_ev);
            nt = q.pop_front();
            `CHK(nt.n, nt.e & nt.m, got)
        end
    end
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // the #1 keeps two notes from sharing one time step and one event
    task automatic note(string n, logic [31:0] e, logic [31:0] m, logic [31:0] g);
        q.push_back(sih_note_type'{n, e, m});
        got = g & m;
        -> res_ev;
        #1;
    endtask
    task automatic fld(string n, logic e, logic g);
        note(n, {31'h0, e}, 32'h1, {31'h0, g});
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdm(logic [7:0] a, logic [31:0] e, logic [31:0] m, string n);
        bus(1'b0, a, 32'h0);
        note(n, e, m, rd);
    endtask
    task automatic reboot();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        settle(4);
    endtask
    task automatic jog(logic fw, logic rv, int n, logic mv);
        @(posedge clk);
        pi.forward_jog_request <= fw;
        pi.reverse_jog_request <= rv;
        s0 = steps;
        settle(n);
        if (mv) begin
            fld("jog_busy", 1'b0, pins_out.ready);
            fld("jog_dir", fw, pins_out.dir_forward);
        end
        @(posedge clk);
        pi.forward_jog_request <= 1'b0;
        pi.reverse_jog_request <= 1'b0;
        for (int i = 0; i < 300 && pins_out.ready !== 1'b1; i++) @(posedge clk);
        #1;
        n_tot = steps - s0;
        fld("jog_moved", mv, n_tot != 0);
        if (mv) fld("jog_end", 1'b1, pins_out.ready);
    endtask
    task automatic home();
        @(posedge clk);
        go <= 1'b1;
        s0 = steps;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 20 && pins_out.ready !== 1'b0; i++) @(posedge clk);
        #1;
        fld("home_busy", 1'b0, pins_out.ready);
        for (int i = 0; i < 400 && !(pins_out.home_done === 1'b1 && pins_out.ready === 1'b1);
            i++) @(posedge clk);
        #1;
        n_tot = steps - s0;
        fld("home_done", 1'b1, pins_out.home_done);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        go = 1'b0;
        sens = 8'h00;
        pi = '0;
        pi.current_on_input = 1'b1;
        reboot();
        fld("rdy_up", 1'b1, pins_out.ready);
        fld("pulse_input_ready_up", 1'b1, pins_out.pulse_input_ready);
        fld("alarm_n_up", 1'b1, pins_out.alarm_output_active_low);
        rdm(SIH_OFF_STATUS, 32'h10, 32'h90, "status");
        rdm(8'h1c, 32'h0, 32'hffff_ffff, "unmapped");
        fld("hresp_okay", 1'b0, hresp);
        d = rnd();
        bus(1'b1, SIH_OFF_HOME, d);
        rdm(SIH_OFF_HOME, d, 32'hffff_ffff, "home_rw");
        bus(1'b1, SIH_OFF_IRQ_MASK, 32'h2);
        rdm(SIH_OFF_IRQ_MASK, 32'h2, 32'h7, "mask");
        jog(1'b1, 1'b0, 20 + int'(rnd() & 32'h0f), 1'b1);
        // home set from the present position, so the way back is known
        bus(1'b1, SIH_OFF_CTRL, 32'h2);
        jog(1'b0, 1'b1, 20 + int'(rnd() & 32'h0f), 1'b1);
        k2 = n_tot;
        home();
        fld("home_steps", 1'b1, n_tot == k2);
        settle(1);
        fld("irq_home", 1'b1, irq);
        bus(1'b1, SIH_OFF_IRQ_STAT, 32'h2);
        settle(1);
        fld("irq_w1c", 1'b0, irq);
        jog(1'b1, 1'b0, 40, 1'b1);
        @(posedge clk);
        sens <= 8'h03;
        home();
        fld("sensor_stop", 1'b1, n_tot == 3);
        @(posedge clk);
        sens <= 8'h00;
        bus(1'b1, SIH_OFF_IRQ_MASK, 32'h0);
        settle(1);
        fld("irq_masked", 1'b0, irq);
        jog(1'b1, 1'b1, 20, 1'b0);
        rdm(SIH_OFF_IRQ_STAT, 32'h4, 32'h4, "conflict");
        jog(1'b0, 1'b1, 20, 1'b1);
        @(posedge clk);
        pi.stop_input <= 1'b1;
        jog(1'b1, 1'b0, 20, 1'b0);
        @(posedge clk);
        pi.stop_input <= 1'b0;
        foreach (wtab[k]) begin
            @(posedge clk);
            {pi.current_on_input, pi.stop_and_deenergize_input, pi.shaft_release_input} <=
                wtab[k][4:2];
            settle(1);
            fld("winding", wtab[k][1], pins_out.winding_enable);
            fld("brake", wtab[k][0], pins_out.dynamic_brake);
        end
        @(posedge clk);
        pi.alarm_cause <= 1'b1;
        settle(3);
        fld("alarm_n", 1'b0, pins_out.alarm_output_active_low);
        // blink phase runs free from reset: wait for the lit half, then the dark half
        for (int i = 0; i < 600 && pins_out.status_red_blink !== 1'b1; i++) @(posedge clk);
        #1;
        fld("red_blink", 1'b1, pins_out.status_red_blink);
        for (int i = 0; i < 600 && pins_out.status_red_blink !== 1'b0; i++) @(posedge clk);
        #1;
        fld("red_dark", 1'b0, pins_out.status_red_blink);
        bus(1'b1, SIH_OFF_CTRL, 32'h1);
        settle(2);
        fld("clr_early", 1'b0, pins_out.alarm_output_active_low);
        @(posedge clk);
        pi.alarm_cause <= 1'b0;
        bus(1'b1, SIH_OFF_CTRL, 32'h1);
        settle(2);
        fld("clr_ok", 1'b1, pins_out.alarm_output_active_low);
        bus(1'b1, SIH_OFF_CTRL, 32'h4);
        settle(2);
        fld("forced", 1'b0, pins_out.alarm_output_active_low);
        bus(1'b1, SIH_OFF_CFG, 32'h1);
        rdm(SIH_OFF_CFG, 32'h1, 32'h1, "cfg");
        @(posedge clk);
        pi.pulse_mode_dip_switch <= 1'b1;
        settle(2);
        fld("mode_held", 1'b0, single_pulse_mode);
        reboot();
        fld("alarm_gone", 1'b1, pins_out.alarm_output_active_low);
        fld("mode_new", 1'b1, single_pulse_mode);
        wrap_up();
    end
endmodule // stepper_io_handshake_tb_top
